// File: hdl/gpio_mux_pkg.sv
// constants, codes and field types of the pin function multiplexer
//
// How it works
// [RQ1] thirty user pins plus six flash pins
// [RQ2] software picks function through select field
// [RQ3] one function active per pin
// [RQ4] function routes output, enable and input
// [RQ5] shared peripheral input sees OR of pins
// [RQ6] out, enable, input invertible or forceable
// [RQ7] F5 drives software pins; input always delivered
// [RQ8] F1 serial controllers, roles by pin mod four
// [RQ9] F2 UARTs, roles by pin mod four
// [RQ10] F3 two-wire controllers, even data, odd clock
// [RQ11] F4 PWM slice pin/2 mod 8, A/B
// [RQ12] PWM channel B pin feeds slice input
// [RQ13] F6/F7 programmable IO, F8 clocks, F9 USB
// [RQ14] flash bank offers only flash and software
// [RQ15] flash F0 execute-in-place, F5 software, fixed order
// [RQ16] unassigned code: driver off, no input
package gpio_mux_pkg;

    // ------------------------------------------------------------
    // bank sizes
    // ------------------------------------------------------------
    localparam int USER_PINS  = 30;
    localparam int FLASH_PINS = 6;
    localparam int ALL_PINS   = USER_PINS + FLASH_PINS;

    // ------------------------------------------------------------
    // function select codes
    // ------------------------------------------------------------
    typedef logic [4:0] func_code_type;
    localparam func_code_type FN_FLASH = 5'h00;
    localparam func_code_type FN_SPI   = 5'h01;
    localparam func_code_type FN_UART  = 5'h02;
    localparam func_code_type FN_I2C   = 5'h03;
    localparam func_code_type FN_PWM   = 5'h04;
    localparam func_code_type FN_SOFT  = 5'h05;
    localparam func_code_type FN_PROG0 = 5'h06;
    localparam func_code_type FN_PROG1 = 5'h07;
    localparam func_code_type FN_CLK   = 5'h08;
    localparam func_code_type FN_USB   = 5'h09;
    localparam func_code_type FN_NULL  = 5'h1f;

    // ------------------------------------------------------------
    // override field: normal, invert, force low, force high
    // ------------------------------------------------------------
    typedef logic [1:0] ovr_type;
    localparam ovr_type OVR_NORMAL = 2'h0;
    localparam ovr_type OVR_INVERT = 2'h1;
    localparam ovr_type OVR_LOW    = 2'h2;
    localparam ovr_type OVR_HIGH   = 2'h3;

    typedef logic [ALL_PINS-1:0][4:0] func_bank_type;
    typedef logic [ALL_PINS-1:0][1:0] ovr_bank_type;

    // ------------------------------------------------------------
    // roles and special pins
    // ------------------------------------------------------------
    localparam int ROLES4       = 4;
    localparam int USB_ROLES    = 3;
    localparam int USB_OVCUR    = 0;
    localparam int USB_VBUS_DET = 1;
    localparam int USB_VBUS_EN  = 2;
    localparam int PWM_SLICES   = 8;
    localparam int CLK_IN0_PIN  = 20;
    localparam int CLK_IN1_PIN  = 22;
    localparam int CLK_OUT0_PIN = 21;
    localparam int CLK_OUT1_PIN = 23;
    localparam int CLK_OUT2_PIN = 24;
    localparam int CLK_OUT3_PIN = 25;
    localparam int INPUT_LAT    = 3;

endpackage

// File: hdl/pad_path_if.sv
// signals between the function multiplexer and the pad conditioner
`timescale 1ns/1ps
`default_nettype none
interface pad_path_if;
    logic [gpio_mux_pkg::ALL_PINS-1:0] raw_out;
    logic [gpio_mux_pkg::ALL_PINS-1:0] raw_oe;
    logic [gpio_mux_pkg::ALL_PINS-1:0] cond_out;
    logic [gpio_mux_pkg::ALL_PINS-1:0] cond_oe;
    logic [gpio_mux_pkg::ALL_PINS-1:0] cond_in;
    gpio_mux_pkg::ovr_bank_type        out_over;
    gpio_mux_pkg::ovr_bank_type        oe_over;
    gpio_mux_pkg::ovr_bank_type        in_over;

    modport mux (output raw_out, raw_oe, out_over, oe_over, in_over,
                 input cond_out, cond_oe, cond_in);
    modport cond (input raw_out, raw_oe, out_over, oe_over, in_over,
                  output cond_out, cond_oe, cond_in);
endinterface
`default_nettype wire

// File: hdl/pad_conditioner.sv
// pin input synchroniser and per-signal invert/force logic
`timescale 1ns/1ps
`default_nettype none
module pad_conditioner (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst,
    // raw pad levels
    input  wire logic [gpio_mux_pkg::ALL_PINS-1:0] pad_in,
    // multiplexer side
    pad_path_if.cond                               pp
);

    logic [gpio_mux_pkg::ALL_PINS-1:0] sync1_reg;
    logic [gpio_mux_pkg::ALL_PINS-1:0] sync2_reg;

    // apply one override setting to a level
    function automatic logic apply_ovr(input logic lvl, input gpio_mux_pkg::ovr_type ovr);
        unique case (ovr)
            gpio_mux_pkg::OVR_NORMAL: apply_ovr = lvl;
            gpio_mux_pkg::OVR_INVERT: apply_ovr = ~lvl;
            gpio_mux_pkg::OVR_LOW:    apply_ovr = 1'b0;
            gpio_mux_pkg::OVR_HIGH:   apply_ovr = 1'b1;
        endcase
    endfunction

    // two-stage synchroniser on pad levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pad_in;
            sync2_reg <= sync1_reg;
        end
    end

    // invert or force each of the three signals
    always_comb begin
        for (int p = 0; p < gpio_mux_pkg::ALL_PINS; p++) begin
            pp.cond_out[p] = apply_ovr(pp.raw_out[p], pp.out_over[p]); // [RQ6]
            pp.cond_oe[p]  = apply_ovr(pp.raw_oe[p], pp.oe_over[p]);   // [RQ6]
            pp.cond_in[p]  = apply_ovr(sync2_reg[p], pp.in_over[p]);   // [RQ6]
        end
    end

    AST_FORCE_LOW_IN: assert property (@(posedge clk) disable iff (rst) // [RQ6]
        pp.in_over[4] == gpio_mux_pkg::OVR_LOW |-> !pp.cond_in[4])
        else $error("forced low input not low");

endmodule
`default_nettype wire

// File: hdl/gpio_function_select_mux.sv
// per-pin function select multiplexer for user and flash banks
`timescale 1ns/1ps
`default_nettype none
module gpio_function_select_mux (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst,
    // pads: 0..29 user, 30 clock, 31 select, 32..35 data
    input  wire logic [gpio_mux_pkg::ALL_PINS-1:0] pad_in,
    output logic      [gpio_mux_pkg::ALL_PINS-1:0] pad_out,
    output logic      [gpio_mux_pkg::ALL_PINS-1:0] pad_oe_n,
    // per-pin control settings
    input  wire gpio_mux_pkg::func_bank_type       function_select_field,
    input  wire gpio_mux_pkg::ovr_bank_type        out_over,
    input  wire gpio_mux_pkg::ovr_bank_type        oe_over,
    input  wire gpio_mux_pkg::ovr_bank_type        in_over,
    // serial peripheral controllers, roles rx, select, clock, tx
    input  wire logic [1:0][3:0]                   spi_out,
    input  wire logic [1:0][3:0]                   spi_oe,
    output logic      [1:0][3:0]                   spi_in,
    // uarts, roles tx, rx, cts, rts
    input  wire logic [1:0][3:0]                   uart_out,
    input  wire logic [1:0][3:0]                   uart_oe,
    output logic      [1:0][3:0]                   uart_in,
    // two-wire controllers, roles data, clock
    input  wire logic [1:0][1:0]                   i2c_out,
    input  wire logic [1:0][1:0]                   i2c_oe,
    output logic      [1:0][1:0]                   i2c_in,
    // pwm slices, channels a, b
    input  wire logic [7:0][1:0]                   pwm_out,
    output logic      [7:0]                        pwm_b_in,
    // software io block
    input  wire logic [gpio_mux_pkg::ALL_PINS-1:0] software_io_out,
    input  wire logic [gpio_mux_pkg::ALL_PINS-1:0] software_io_oe,
    output logic      [gpio_mux_pkg::ALL_PINS-1:0] software_io_in,
    // programmable io blocks
    input  wire logic [29:0]                       pio_zero_out,
    input  wire logic [29:0]                       pio_zero_oe,
    input  wire logic [29:0]                       pio_one_out,
    input  wire logic [29:0]                       pio_one_oe,
    output logic      [29:0]                       pio_in,
    // auxiliary clocks
    output logic      [1:0]                        aux_clock_input,
    input  wire logic [3:0]                        aux_clock_output,
    // usb power control
    output logic                                   usb_overcurrent_detect,
    output logic                                   usb_vbus_detect,
    input  wire logic                              usb_vbus_enable,
    // flash execute-in-place interface, same order as the pads
    input  wire logic [5:0]                        flash_exec_out,
    input  wire logic [5:0]                        flash_exec_oe,
    output logic      [5:0]                        flash_exec_in
);

    pad_path_if pp ();

    logic [gpio_mux_pkg::ALL_PINS-1:0] pad_out_reg;
    logic [gpio_mux_pkg::ALL_PINS-1:0] pad_oe_n_reg;
    logic [1:0][3:0]                   spi_in_reg;
    logic [1:0][3:0]                   spi_in_next;
    logic [1:0][3:0]                   uart_in_reg;
    logic [1:0][3:0]                   uart_in_next;
    logic [1:0][1:0]                   i2c_in_reg;
    logic [1:0][1:0]                   i2c_in_next;
    logic [7:0]                        pwm_b_in_reg;
    logic [7:0]                        pwm_b_in_next;
    logic [gpio_mux_pkg::ALL_PINS-1:0] soft_in_reg;
    logic [29:0]                       pio_in_reg;
    logic [1:0]                        aux_in_reg;
    logic [1:0]                        aux_in_next;
    logic [2:0]                        usb_in_reg;
    logic [2:0]                        usb_in_next;
    logic [5:0]                        flash_in_reg;
    logic [5:0]                        flash_in_next;
    logic [1:0]                        up_cnt_reg;

    // ------------------------------------------------------------
    // pin to peripheral decoding
    // ------------------------------------------------------------

    // role of a pin inside a group of four
    function automatic int role4(input int pin);
        role4 = pin % gpio_mux_pkg::ROLES4;
    endfunction

    // serial controller number: pins 0-7, 16-23 unit 0
    function automatic int spi_unit(input int pin);
        spi_unit = (pin / 8) % 2;
    endfunction

    // uart number: pins 4-11, 20-27 unit 1
    function automatic int uart_unit(input int pin);
        uart_unit = ((pin + 4) / 8) % 2;
    endfunction

    // two-wire unit: pins 0-1 unit 0, 2-3 unit 1, repeating every four
    function automatic int pair_unit(input int pin);
        pair_unit = (pin / 2) % 2;
    endfunction

    // ------------------------------------------------------------
    // conditioner instance
    // ------------------------------------------------------------
    pad_conditioner u_cond (
        .clk    (clk),
        .rst    (rst),
        .pad_in (pad_in),
        .pp     (pp.cond)
    );

    assign pp.out_over = out_over;
    assign pp.oe_over  = oe_over;
    assign pp.in_over  = in_over;

    // ------------------------------------------------------------
    // function multiplexer
    // ------------------------------------------------------------

    // route the chosen function's signals; inputs merged by OR
    always_comb begin
        pp.raw_out    = '0;
        pp.raw_oe     = '0; // [RQ16]
        spi_in_next   = '0;
        uart_in_next  = '0;
        i2c_in_next   = '0;
        pwm_b_in_next = '0;
        aux_in_next   = '0;
        usb_in_next   = '0;
        flash_in_next = '0;
        for (int p = 0; p < gpio_mux_pkg::USER_PINS; p++) begin // [RQ1]
            unique case (function_select_field[p]) // [RQ2] [RQ3] [RQ4]
                gpio_mux_pkg::FN_SPI: begin
                    pp.raw_out[p] = spi_out[spi_unit(p)][role4(p)]; // [RQ8]
                    pp.raw_oe[p]  = spi_oe[spi_unit(p)][role4(p)];
                    spi_in_next[spi_unit(p)][role4(p)] |= pp.cond_in[p]; // [RQ5]
                end
                gpio_mux_pkg::FN_UART: begin
                    pp.raw_out[p] = uart_out[uart_unit(p)][role4(p)]; // [RQ9]
                    pp.raw_oe[p]  = uart_oe[uart_unit(p)][role4(p)];
                    uart_in_next[uart_unit(p)][role4(p)] |= pp.cond_in[p]; // [RQ5]
                end
                gpio_mux_pkg::FN_I2C: begin
                    pp.raw_out[p] = i2c_out[pair_unit(p)][p % 2]; // [RQ10]
                    pp.raw_oe[p]  = i2c_oe[pair_unit(p)][p % 2];
                    i2c_in_next[pair_unit(p)][p % 2] |= pp.cond_in[p];
                end
                gpio_mux_pkg::FN_PWM: begin
                    pp.raw_out[p] = pwm_out[(p / 2) % gpio_mux_pkg::PWM_SLICES][p % 2]; // [RQ11]
                    pp.raw_oe[p]  = 1'b1;
                    if (p % 2 == 1) begin
                        pwm_b_in_next[(p / 2) % gpio_mux_pkg::PWM_SLICES] |= pp.cond_in[p]; // [RQ12]
                    end
                end
                gpio_mux_pkg::FN_SOFT: begin
                    pp.raw_out[p] = software_io_out[p]; // [RQ7]
                    pp.raw_oe[p]  = software_io_oe[p];
                end
                gpio_mux_pkg::FN_PROG0: begin
                    pp.raw_out[p] = pio_zero_out[p]; // [RQ13]
                    pp.raw_oe[p]  = pio_zero_oe[p];
                end
                gpio_mux_pkg::FN_PROG1: begin
                    pp.raw_out[p] = pio_one_out[p]; // [RQ13]
                    pp.raw_oe[p]  = pio_one_oe[p];
                end
                gpio_mux_pkg::FN_CLK: begin
                    // clock pins only; others stay undriven
                    unique case (p)
                        gpio_mux_pkg::CLK_IN0_PIN:  aux_in_next[0] = pp.cond_in[p]; // [RQ13]
                        gpio_mux_pkg::CLK_IN1_PIN:  aux_in_next[1] = pp.cond_in[p];
                        gpio_mux_pkg::CLK_OUT0_PIN: pp.raw_out[p]  = aux_clock_output[0];
                        gpio_mux_pkg::CLK_OUT1_PIN: pp.raw_out[p]  = aux_clock_output[1];
                        gpio_mux_pkg::CLK_OUT2_PIN: pp.raw_out[p]  = aux_clock_output[2];
                        gpio_mux_pkg::CLK_OUT3_PIN: pp.raw_out[p]  = aux_clock_output[3];
                        default: ; // [RQ16]
                    endcase
                    pp.raw_oe[p] = (p == gpio_mux_pkg::CLK_OUT0_PIN) || (p == gpio_mux_pkg::CLK_OUT1_PIN) ||
                                   (p == gpio_mux_pkg::CLK_OUT2_PIN) || (p == gpio_mux_pkg::CLK_OUT3_PIN);
                end
                gpio_mux_pkg::FN_USB: begin
                    // roles cycle by pin mod three
                    if (p % gpio_mux_pkg::USB_ROLES == gpio_mux_pkg::USB_VBUS_EN) begin
                        pp.raw_out[p] = usb_vbus_enable; // [RQ13]
                        pp.raw_oe[p]  = 1'b1;
                    end else begin
                        usb_in_next[p % gpio_mux_pkg::USB_ROLES] |= pp.cond_in[p];
                    end
                end
                default: ; // [RQ16]
            endcase
        end
        for (int k = 0; k < gpio_mux_pkg::FLASH_PINS; k++) begin // [RQ14]
            unique case (function_select_field[gpio_mux_pkg::USER_PINS + k])
                gpio_mux_pkg::FN_FLASH: begin
                    pp.raw_out[gpio_mux_pkg::USER_PINS + k] = flash_exec_out[k]; // [RQ15]
                    pp.raw_oe[gpio_mux_pkg::USER_PINS + k]  = flash_exec_oe[k];
                    flash_in_next[k] = pp.cond_in[gpio_mux_pkg::USER_PINS + k];
                end
                gpio_mux_pkg::FN_SOFT: begin
                    pp.raw_out[gpio_mux_pkg::USER_PINS + k] = software_io_out[gpio_mux_pkg::USER_PINS + k]; // [RQ15]
                    pp.raw_oe[gpio_mux_pkg::USER_PINS + k]  = software_io_oe[gpio_mux_pkg::USER_PINS + k];
                end
                default: ; // [RQ16]
            endcase
        end
    end

    // ------------------------------------------------------------
    // registered pad drive
    // ------------------------------------------------------------

    // pad level and active-low enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_out_reg  <= '0;
            pad_oe_n_reg <= '1;
        end else begin
            pad_out_reg  <= pp.cond_out;
            pad_oe_n_reg <= ~pp.cond_oe; // [RQ4]
        end
    end

    // ------------------------------------------------------------
    // registered peripheral inputs
    // ------------------------------------------------------------

    // function-specific inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spi_in_reg   <= '0;
            uart_in_reg  <= '0;
            i2c_in_reg   <= '0;
            pwm_b_in_reg <= '0;
        end else begin
            spi_in_reg   <= spi_in_next;
            uart_in_reg  <= uart_in_next;
            i2c_in_reg   <= i2c_in_next;
            pwm_b_in_reg <= pwm_b_in_next;
        end
    end

    // clock, usb and flash inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aux_in_reg   <= '0;
            usb_in_reg   <= '0;
            flash_in_reg <= '0;
        end else begin
            aux_in_reg   <= aux_in_next;
            usb_in_reg   <= usb_in_next;
            flash_in_reg <= flash_in_next;
        end
    end

    // inputs always seen by software and programmable io
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            soft_in_reg <= '0;
            pio_in_reg  <= '0;
        end else begin
            soft_in_reg <= pp.cond_in; // [RQ7]
            pio_in_reg <= pp.cond_in[gpio_mux_pkg::USER_PINS-1:0];
        end
    end

    // cycles since reset, for input-latency checks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_cnt_reg <= '0;
        end else if (up_cnt_reg != 2'(gpio_mux_pkg::INPUT_LAT)) begin
            up_cnt_reg <= up_cnt_reg + 2'h1;
        end
    end

    assign pad_out                = pad_out_reg;
    assign pad_oe_n               = pad_oe_n_reg;
    assign spi_in                 = spi_in_reg;
    assign uart_in                = uart_in_reg;
    assign i2c_in                 = i2c_in_reg;
    assign pwm_b_in               = pwm_b_in_reg;
    assign software_io_in         = soft_in_reg;
    assign pio_in                 = pio_in_reg;
    assign aux_clock_input        = aux_in_reg;
    assign usb_overcurrent_detect = usb_in_reg[gpio_mux_pkg::USB_OVCUR];
    assign usb_vbus_detect        = usb_in_reg[gpio_mux_pkg::USB_VBUS_DET];
    assign flash_exec_in          = flash_in_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    AST_NULL_UNDRIVEN: assert property (@(posedge clk) disable iff (rst) // [RQ16]
        function_select_field[0] == gpio_mux_pkg::FN_NULL && oe_over[0] == gpio_mux_pkg::OVR_NORMAL
        |=> pad_oe_n[0])
        else $error("unassigned pin is driven");

    AST_SOFT_DRIVE: assert property (@(posedge clk) disable iff (rst) // [RQ7]
        function_select_field[5] == gpio_mux_pkg::FN_SOFT && out_over[5] == gpio_mux_pkg::OVR_NORMAL
        && oe_over[5] == gpio_mux_pkg::OVR_NORMAL
        |=> pad_out[5] == $past(software_io_out[5]) && pad_oe_n[5] == !$past(software_io_oe[5]))
        else $error("software drive not on pin 5");

    AST_SOFT_INPUT: assert property (@(posedge clk) disable iff (rst) // [RQ7]
        up_cnt_reg == 2'(gpio_mux_pkg::INPUT_LAT) && $past(in_over[3]) == gpio_mux_pkg::OVR_NORMAL
        |-> software_io_in[3] == $past(pad_in[3], 3))
        else $error("pin 3 level not seen by software");

    AST_OR_MERGE: assert property (@(posedge clk) disable iff (rst) // [RQ5]
        function_select_field[1] == gpio_mux_pkg::FN_UART && function_select_field[13] == gpio_mux_pkg::FN_UART
        |=> uart_in[0][1] == $past(pp.cond_in[1] | pp.cond_in[13]
            | (pp.cond_in[17] & (function_select_field[17] == gpio_mux_pkg::FN_UART))
            | (pp.cond_in[29] & (function_select_field[29] == gpio_mux_pkg::FN_UART))))
        else $error("uart0 rx not OR of pins");

    AST_PWM_B_IN: assert property (@(posedge clk) disable iff (rst) // [RQ12]
        function_select_field[3] == gpio_mux_pkg::FN_PWM |=> pwm_b_in[1] == $past(pp.cond_in[3]
            | (pp.cond_in[19] & (function_select_field[19] == gpio_mux_pkg::FN_PWM))))
        else $error("pwm slice 1 b input wrong");

    AST_FORCE_HIGH: assert property (@(posedge clk) disable iff (rst) // [RQ6]
        out_over[7] == gpio_mux_pkg::OVR_HIGH |=> pad_out[7])
        else $error("forced high output not high");

    AST_INVERT_OE: assert property (@(posedge clk) disable iff (rst) // [RQ6]
        function_select_field[0] == gpio_mux_pkg::FN_SOFT && oe_over[0] == gpio_mux_pkg::OVR_INVERT
        |=> pad_oe_n[0] == $past(software_io_oe[0]))
        else $error("inverted enable wrong");

    AST_FLASH_EXEC: assert property (@(posedge clk) disable iff (rst) // [RQ15]
        function_select_field[30] == gpio_mux_pkg::FN_FLASH && out_over[30] == gpio_mux_pkg::OVR_NORMAL
        |=> pad_out[30] == $past(flash_exec_out[0]))
        else $error("flash clock not routed");

    AST_SPI_TX: assert property (@(posedge clk) disable iff (rst) // [RQ8]
        function_select_field[27] == gpio_mux_pkg::FN_SPI && out_over[27] == gpio_mux_pkg::OVR_NORMAL
        |=> pad_out[27] == $past(spi_out[1][3]))
        else $error("spi1 tx not on pin 27");

    AST_UART_TX: assert property (@(posedge clk) disable iff (rst) // [RQ9]
        function_select_field[20] == gpio_mux_pkg::FN_UART && out_over[20] == gpio_mux_pkg::OVR_NORMAL
        |=> pad_out[20] == $past(uart_out[1][0]))
        else $error("uart1 tx not on pin 20");

endmodule
`default_nettype wire

// File: tb/pad_far_side.sv
// far side of the pads: external circuitry resolved against the pin drivers
`timescale 1ns/1ps
`default_nettype none
module pad_far_side (
    // pin drivers and external levels
    input  wire logic [35:0] pad_out,
    input  wire logic [35:0] pad_oe_n,
    input  wire logic [35:0] ext_level,
    // resolved wire
    output logic      [35:0] pad_in
);
    // a driving pin wins, a released pin shows the external level
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_level);
endmodule
`default_nettype wire

// File: tb/gpio_function_select_mux_tb_top.sv
// self-checking bench of the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module gpio_function_select_mux_tb_top;
    // clock, reset, counters and stimulus
    logic clk, rst;
    logic [31:0] seed;
    logic [319:0] pool;
    int err_total, total_checks;
    logic [35:0] pad_in, pad_out, pad_oe_n, ext, sw_o, sw_e, sw_i, e_out, e_oe, care, e_in;
    gpio_mux_pkg::func_bank_type fs;
    gpio_mux_pkg::ovr_bank_type oo, eo, io;
    logic [1:0][3:0] spi_o, spi_e, spi_i, u_o, u_e, u_i, e_spi, e_u;
    logic [1:0][1:0] i_o, i_e, i_i, e_i2c;
    logic [7:0][1:0] pw_o;
    logic [7:0] pw_i, e_pw;
    logic [29:0] p0o, p0e, p1o, p1e, pio_i;
    logic [5:0] x_o, x_e, x_i, e_x;
    logic [3:0] ck_o;
    logic [1:0] ck_i, e_ck, e_usb;
    logic ven, ovc, vdet;
    // random pool spread over the peripheral outputs and external levels
    assign {sw_o, sw_e, ext, spi_o, spi_e, u_o, u_e, i_o, i_e, pw_o, p0o, p0e, p1o, p1e, ck_o, ven, x_o, x_e}
        = pool[300:0];
    gpio_function_select_mux gpio_function_select_mux_inst (.clk(clk), .rst(rst), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .function_select_field(fs), .out_over(oo), .oe_over(eo),
        .in_over(io), .spi_out(spi_o), .spi_oe(spi_e), .spi_in(spi_i), .uart_out(u_o), .uart_oe(u_e),
        .uart_in(u_i), .i2c_out(i_o), .i2c_oe(i_e), .i2c_in(i_i), .pwm_out(pw_o), .pwm_b_in(pw_i),
        .software_io_out(sw_o), .software_io_oe(sw_e), .software_io_in(sw_i), .pio_zero_out(p0o),
        .pio_zero_oe(p0e), .pio_one_out(p1o), .pio_one_oe(p1e), .pio_in(pio_i), .aux_clock_input(ck_i),
        .aux_clock_output(ck_o), .usb_overcurrent_detect(ovc), .usb_vbus_detect(vdet),
        .usb_vbus_enable(ven), .flash_exec_out(x_o), .flash_exec_oe(x_e), .flash_exec_in(x_i));
    pad_far_side pad_far_side_inst (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext), .pad_in(pad_in));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // normal, invert, force low, force high
    function automatic logic ov(input logic v, input logic [1:0] o);
        return o[1] ? o[0] : (v ^ o[0]);
    endfunction
    task automatic chk(input string nm, input logic [35:0] ex, input logic [35:0] got);
        total_checks++;
        if (got !== ex) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // new random codes, overrides and peripheral levels, on the clock edge
    task automatic drive;
        logic [319:0] nx;
        for (int q = 0; q < 36; q++) begin
            seed = xs(seed);
            fs[q] <= (seed % 11 == 10) ? 5'h1f : 5'(seed % 11);
            oo[q] <= seed[8] ? seed[5:4] : 2'h0;
            eo[q] <= seed[9] ? seed[7:6] : 2'h0;
            io[q] <= seed[10] ? seed[12:11] : 2'h0;
        end
        for (int k = 0; k < 10; k++) begin
            seed = xs(seed);
            nx = {nx[287:0], seed};
        end
        pool <= nx;
    endtask
    // reference routing of every pin
    task automatic model;
        logic o, e, c;
        {e_spi, e_u, e_i2c, e_pw, e_x, e_ck, e_usb} = '0;
        for (int q = 0; q < 36; q++) begin
            c = ov(pad_in[q], io[q]);
            e_in[q] = c;
            {o, e} = 2'h0;
            if (q >= 30) begin
                if (fs[q] == 5'h00) {o, e} = {x_o[q-30], x_e[q-30]};
                if (fs[q] == 5'h05) {o, e} = {sw_o[q], sw_e[q]};
                e_x[q-30] = (fs[q] == 5'h00) & c;
            end else case (fs[q])
                5'h01: begin
                    {o, e} = {spi_o[q/8%2][q%4], spi_e[q/8%2][q%4]};
                    e_spi[q/8%2][q%4] |= c;
                end
                5'h02: begin
                    {o, e} = {u_o[(q+4)/8%2][q%4], u_e[(q+4)/8%2][q%4]};
                    e_u[(q+4)/8%2][q%4] |= c;
                end
                5'h03: begin
                    {o, e} = {i_o[q%4/2][q%2], i_e[q%4/2][q%2]};
                    e_i2c[q%4/2][q%2] |= c;
                end
                5'h04: begin
                    {o, e} = {pw_o[q/2%8][q%2], 1'b1};
                    if (q % 2 == 1) e_pw[q/2%8] |= c;
                end
                5'h05: {o, e} = {sw_o[q], sw_e[q]};
                5'h06: {o, e} = {p0o[q], p0e[q]};
                5'h07: {o, e} = {p1o[q], p1e[q]};
                5'h08: begin
                    if (q == 21 || (q > 22 && q < 26)) {o, e} = {ck_o[q == 21 ? 0 : q - 22], 1'b1};
                    if (q == 20 || q == 22) e_ck[q / 2 - 10] = c;
                end
                5'h09: if (q % 3 == 2) {o, e} = {ven, 1'b1};
                else e_usb[q % 3] |= c;
                default: ;
            endcase
            care[q] = e | oo[q][1];
            e_out[q] = ov(o, oo[q]);
            e_oe[q] = ~ov(e, eo[q]);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watchdog well past 200 rounds of nine cycles
    initial begin
        #200000;
        err_total++;
        stop_test;
    end
    initial begin
        {rst, seed, pool, fs, oo, eo, io} = {1'b1, 32'h0000c3a4, 320'h0, 180'h0, 216'h0};
        err_total = 0;
        total_checks = 0;
        repeat (4) @(posedge clk);
        chk("reset pad_oe_n", '1, pad_oe_n);
        rst <= 1'b0;
        repeat (200) begin
            @(posedge clk);
            drive;
            repeat (8) @(posedge clk);
            #1;
            model;
            chk("pad_out", e_out & care, pad_out & care);
            chk("pad_oe_n", e_oe, pad_oe_n);
            chk("software_io_in", e_in, sw_i);
            chk("pio_in", 36'(e_in[29:0]), 36'(pio_i));
            chk("uart_in", 36'(e_u), 36'(u_i));
            chk("spi_in", 36'(e_spi), 36'(spi_i));
            chk("i2c_in", 36'(e_i2c), 36'(i_i));
            chk("pwm_b_in", 36'(e_pw), 36'(pw_i));
            chk("flash_exec_in", 36'(e_x), 36'(x_i));
            chk("aux_clock_input", 36'(e_ck), 36'(ck_i));
            chk("usb_in", 36'(e_usb), 36'({vdet, ovc}));
        end
        stop_test;
    end
endmodule
`default_nettype wire
